// ### bench/ext_bus_properties.sv
// Watches the bus port pins against the sequencer walk
module ext_bus_checker #(
  parameter int unsigned ADDR_W = 24
) (
  input wire logic               clk,
  input wire logic               nrst,
  input wire logic               req_valid,
  input wire ext_bus_pkg::kind_t req_kind,
  input wire logic [ADDR_W-1:0]  req_addr,
  input wire logic               req_ready,
  input wire logic               fetch_internal,
  input wire logic               done,
  input wire logic               code_source_select,
  input wire logic [7:0]         low_port_oe,
  input wire logic               ale,
  input wire logic               rd_n,
  input wire logic               wr_n,
  input wire logic               program_store_strobe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Taken requests by kind
  wire logic go = req_valid && req_ready;
  wire logic in_win = code_source_select && (req_addr <= 24'h001fff);
  // Read and write strobes never overlap
  property p_excl;
    !(!rd_n && !wr_n);
  endproperty
  a_excl: assert property (p_excl)
    else $error("read and write strobes together");
  // A strobe falls only two cycles after the latch pulse
  property p_after_ale;
    $fell(rd_n) || $fell(wr_n) |-> !ale && $past(ale, 2);
  endproperty
  a_after_ale: assert property (p_after_ale)
    else $error("strobe before address phase");
  // Latch strobe is a one-cycle pulse
  property p_ale_pulse;
    $rose(ale) |=> !ale;
  endproperty
  a_ale_pulse: assert property (p_ale_pulse)
    else $error("latch strobe too wide");
  // Port released while memory drives it in a read
  property p_rd_release;
    !rd_n |-> low_port_oe == 8'h00;
  endproperty
  a_rd_release: assert property (p_rd_release)
    else $error("low port driven in read");
  // Read strobe walk from the taking edge
  property p_rd_walk;
    go && req_kind == ext_bus_pkg::kind_read |-> ##3 !rd_n [*2] ##1 rd_n ##1 done;
  endproperty
  a_rd_walk: assert property (p_rd_walk)
    else $error("read strobe timing");
  // Write strobe walk from the taking edge
  property p_wr_walk;
    go && req_kind == ext_bus_pkg::kind_write |-> ##3 !wr_n [*2] ##1 wr_n ##1 done;
  endproperty
  a_wr_walk: assert property (p_wr_walk)
    else $error("write strobe timing");
  // Program strobe quiet in data cycles
  property p_pss_quiet;
    !rd_n || !wr_n |-> program_store_strobe_out;
  endproperty
  a_pss_quiet: assert property (p_pss_quiet)
    else $error("program strobe in data cycle");
  // Internal fetch ends at once, strobe stays high
  property p_int_fetch;
    go && req_kind == ext_bus_pkg::kind_fetch && in_win
      |-> ##1 fetch_internal && done && program_store_strobe_out;
  endproperty
  a_int_fetch: assert property (p_int_fetch)
    else $error("internal fetch wrong");
  // External fetch pulses the program strobe
  property p_ext_fetch;
    go && req_kind == ext_bus_pkg::kind_fetch && !in_win
      |-> ##3 !program_store_strobe_out [*2] ##1 program_store_strobe_out;
  endproperty
  a_ext_fetch: assert property (p_ext_fetch)
    else $error("external fetch strobe wrong");
  c_read: cover property (go && req_kind == ext_bus_pkg::kind_read);
  c_write: cover property (go && req_kind == ext_bus_pkg::kind_write);
  c_int: cover property (fetch_internal);
  c_ext_fetch: cover property (go && req_kind == ext_bus_pkg::kind_fetch && !in_win);
endmodule : ext_bus_checker

bind external_memory_bus_port ext_bus_checker #(.ADDR_W(ADDR_W)) chk (.clk(clk), .nrst(nrst),
  .req_valid(req_valid), .req_kind(req_kind), .req_addr(req_addr), .req_ready(req_ready),
  .fetch_internal(fetch_internal), .done(done), .code_source_select(code_source_select),
  .low_port_oe(low_port_oe), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
  .program_store_strobe_out(program_store_strobe_out));

// ### bench/ext_memory_model.sv
// External memory with address latch on the multiplexed port
module ext_memory_model (
  input  wire logic       ale,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       pss_n,
  input  wire logic [7:0] bus,
  output logic      [7:0] drive
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];   // Keyed by latched low byte only
  logic [7:0] low_addr;    // External address latch
  logic [7:0] last;        // Last byte driven
  always @(negedge ale) low_addr = bus;
  always @(posedge wr_n) mem[low_addr] = bus;
  // drive while enabled; released lines hold the inverse of the last byte driven
  always @* begin
    if (!rd_n || !pss_n) begin
      drive = mem[low_addr];
      last  = drive;
    end else begin
      drive = ~last;
    end
  end
  initial last = 8'h00;
endmodule : ext_memory_model

// ### bench/external_memory_bus_port_test.sv
module external_memory_bus_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, nrst = 0, req_valid = 0, css = 1, strap_low = 1;
  ext_bus_pkg::kind_t req_kind = ext_bus_pkg::kind_fetch;
  logic [23:0] req_addr = 24'h000000;
  logic [7:0]  req_wdata = 8'h00, low_latch = 8'h5a, upper_latch = 8'hc3;
  logic [7:0]  rdata, lo_out, lo_oe, up_out, up_oe, page, mem_drv;
  logic        ready, fint, done, ale, rd_n, wr_n, pss, pss_oe, dl;
  int          num_errors = 0, num_checks = 0;
  wire logic [7:0] lo_in = (lo_out & lo_oe) | (mem_drv & ~lo_oe);
  // board resistor pulls low only while the pin is released
  wire logic pss_pin = pss_oe ? pss : ~strap_low;
  always #12.5 clk = ~clk;
  external_memory_bus_port uut (.clk(clk), .nrst(nrst), .req_valid(req_valid),
    .req_kind(req_kind), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(ready),
    .fetch_internal(fint), .done(done), .rdata(rdata), .low_latch(low_latch),
    .upper_latch(upper_latch), .code_source_select(css), .low_port_in(lo_in),
    .low_port_out(lo_out), .low_port_oe(lo_oe), .upper_port_in(up_out),
    .upper_port_out(up_out), .upper_port_oe(up_oe), .page_out(page), .ale(ale), .rd_n(rd_n),
    .wr_n(wr_n), .program_store_strobe_in(pss_pin),
    .program_store_strobe_out(pss), .program_store_strobe_oe(pss_oe), .download_mode(dl));
  ext_memory_model mem (.ale(ale), .rd_n(rd_n), .wr_n(wr_n), .pss_n(pss), .bus(lo_in),
    .drive(mem_drv));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    num_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  // Reset for 16 cycles with the strap held as asked
  task automatic do_reset(input logic strap);
    strap_low = strap;
    nrst = 0;
    repeat (16) @(negedge clk);
    check(pss_oe, 1'b0);
    check(ready, 1'b0);
    nrst = 1;
    repeat (2) @(negedge clk);
    strap_low = 0;
    check(dl, strap);
    check(pss_oe, 1'b1);
    check(pss, 1'b1);
    check(ready, 1'b1);
  endtask : do_reset
  // Idle general port behaviour
  task automatic idle_ports;
    check(lo_oe, ~low_latch);
    check(lo_out, 8'h00);
    check(up_out, upper_latch);
    check(up_oe, 8'hff);
  endtask : idle_ports
  // One bus request, walked through its address and strobe phases
  task automatic op(input ext_bus_pkg::kind_t k, input logic [23:0] a, input logic [7:0] d,
                    input logic intern, input logic [7:0] want);
    int n;
    req_kind = k;
    req_addr = a;
    req_wdata = d;
    req_valid = 1;
    @(negedge clk);
    req_valid = 0;
    if (!intern) begin
      check(ale, 1'b1);
      check(lo_out, a[7:0]);
      check(lo_oe, 8'hff);
      check(up_out, a[15:8]);
      if (k != ext_bus_pkg::kind_fetch) check(page, a[23:16]);
      repeat (2) @(negedge clk);
      if (k == ext_bus_pkg::kind_write) check(lo_out & lo_oe, d);
      if (k == ext_bus_pkg::kind_write) check(wr_n, 1'b0);
      if (k == ext_bus_pkg::kind_read) check(rd_n, 1'b0);
      if (k == ext_bus_pkg::kind_fetch) check(pss, 1'b0);
    end else begin
      check(pss, 1'b1);
    end
    n = 0;
    while (done !== 1'b1 && n < 12) begin
      @(negedge clk);
      n++;
    end
    check(done, 1'b1);
    check(fint, intern);
    if (!intern) check(ready, 1'b1);
    if (k != ext_bus_pkg::kind_write) check(rdata, want);
    @(negedge clk);
  endtask : op
  initial begin
    do_reset(1'b1);
    do_reset(1'b0);
    idle_ports();
    op(ext_bus_pkg::kind_write, 24'h1234a5, 8'hff, 1'b0, 8'h00);
    op(ext_bus_pkg::kind_write, 24'h56783c, 8'h3c, 1'b0, 8'h00);
    op(ext_bus_pkg::kind_read, 24'h1234a5, 8'h00, 1'b0, 8'hff);
    op(ext_bus_pkg::kind_read, 24'h00003c, 8'h00, 1'b0, 8'h3c);
    op(ext_bus_pkg::kind_fetch, 24'h001fff, 8'h00, 1'b1, 8'h3c);
    op(ext_bus_pkg::kind_fetch, 24'h0020a5, 8'h00, 1'b0, 8'hff);
    // select always driven, never left floating
    css = 0;
    op(ext_bus_pkg::kind_fetch, 24'h00003c, 8'h00, 1'b0, 8'h3c);
    idle_ports();
    end_of_test();
  end
  initial begin
    #(25 * 2000);
    num_errors++;
    end_of_test();
  end
endmodule : external_memory_bus_port_test

// ### rtl/external_memory_bus_port.sv
`include "ext_bus_params.svh"
// Functional notes
// - Low port: eight open-drain bidirectional lines
// - Latch one floats the low pin
// - Low port multiplexes address then data
// - Bus ones driven strongly, not floated
// - Upper pin with latch one pulled high
// - Upper port drives high address on fetch
// - Upper port drives middle/high for data
// - Address latch strobe pulses per bus cycle
// - Read strobe low; memory drives low port
// - Write drives data, pulses write strobe
// - Program strobe each six periods, not data; here it is low two clocks once per external fetch
// - Program strobe high for internal execution
// - Strap low at reset selects download mode
// - Code source select picks internal/external code
module external_memory_bus_port #(
  parameter int unsigned ADDR_W = 24
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              req_valid,        // Core request, one-cycle pulse
  input  wire ext_bus_pkg::kind_t req_kind,        // Fetch, read or write
  input  wire logic [ADDR_W-1:0] req_addr,         // Fetch also decodes bits above 15; an external fetch loads them to page_out
  input  wire logic [7:0]        req_wdata,        // Write data
  output logic                   req_ready,        // Idle and able to take
  output logic                   fetch_internal,   // Fetch served internally
  output logic                   done,             // One-cycle end of cycle
  output logic [7:0]             rdata,            // Captured read or fetch byte
  input  wire logic [7:0]        low_latch,        // Low port general latch
  input  wire logic [7:0]        upper_latch,      // Upper port general latch
  input  wire logic              code_source_select, // High: internal code window
  input  wire logic [7:0]        low_port_in,
  output logic [7:0]             low_port_out,
  output logic [7:0]             low_port_oe,
  input  wire logic [7:0]        upper_port_in,    // Read back by core elsewhere
  output logic [7:0]             upper_port_out,
  output logic [7:0]             upper_port_oe,
  output logic [7:0]             page_out,         // Page byte, address bits above 15, on its own port
  output logic                   ale,              // Address latch strobe, high active
  output logic                   rd_n,
  output logic                   wr_n,
  input  wire logic              program_store_strobe_in,
  output logic                   program_store_strobe_out,
  output logic                   program_store_strobe_oe,
  output logic                   download_mode
);
  ext_bus_pkg::state_t state, next_state;
  ext_bus_pkg::kind_t  kind, next_kind;
  logic [ADDR_W-1:0]   addr, next_addr;
  logic [7:0]          wdata, next_wdata;
  logic [3:0]          count, next_count;     // Phase timer
  logic                next_req_ready, next_fetch_internal, next_done;
  logic [7:0]          next_rdata, next_low_out, next_low_oe;
  logic [7:0]          next_up_out, next_up_oe, next_page;
  logic                next_ale, next_rd_n, next_wr_n, next_pss, next_pss_oe;

  // Fetch stays inside when select high and address in window
  function automatic logic is_internal(input logic sel, input logic [ADDR_W-1:0] a);
    is_internal = sel && (a[15:0] <= `INTERNAL_CODE_TOP) && (a[ADDR_W-1:16] == '0);
  endfunction : is_internal

  // Open-drain port: a latch one releases the pin
  function automatic logic [7:0] od_enable(input logic [7:0] latch);
    od_enable = ~latch;
  endfunction : od_enable

  // Download strap, sampled once after release
  strap_capture u_strap (
    .clk           (clk),
    .nrst          (nrst),
    .strap_pin     (program_store_strobe_in),
    .download_mode (download_mode)
  );

  // Sequencer and pin next values
  always_comb begin
    next_state          = state;
    next_kind           = kind;
    next_addr           = addr;
    next_wdata          = wdata;
    next_count          = count;
    next_req_ready      = 1'b0;
    next_fetch_internal = 1'b0;
    next_done           = 1'b0;
    next_rdata          = rdata;
    next_low_out        = 8'h00;
    next_low_oe         = od_enable(low_latch);
    next_up_out         = upper_latch;
    next_up_oe          = 8'hff;
    next_page           = page_out;
    next_ale            = 1'b0;
    next_rd_n           = 1'b1;
    next_wr_n           = 1'b1;
    next_pss            = 1'b1;
    // strap pin released only in reset
    next_pss_oe         = 1'b1;
    case (state)
      ext_bus_pkg::st_idle: begin
        next_req_ready = 1'b1;
        if (req_valid && req_ready) begin
          if (req_kind == ext_bus_pkg::kind_fetch && is_internal(code_source_select, req_addr)) begin
            next_fetch_internal = 1'b1;
            next_done           = 1'b1;
            next_req_ready      = 1'b0;
          end else begin
            next_kind      = req_kind;
            next_addr      = req_addr;
            next_wdata     = req_wdata;
            next_count     = `ALE_HIGH_CYCLES;
            next_state     = ext_bus_pkg::st_address;
            next_req_ready = 1'b0;
            // latch strobe with low and page byte
            next_ale       = 1'b1;
            next_low_out   = req_addr[7:0];
            next_low_oe    = 8'hff;
            next_page      = req_addr[ADDR_W-1:16];
          end
        end
      end
      ext_bus_pkg::st_address: begin
        next_low_out = addr[7:0];
        next_low_oe  = 8'hff;
        next_count   = count - 4'h1;
        next_ale     = (count > 4'h1);
        if (count == 4'h1) begin
          next_state = ext_bus_pkg::st_turn;
        end
      end
      ext_bus_pkg::st_turn: begin
        next_count = `STROBE_CYCLES;
        next_state = ext_bus_pkg::st_strobe;
        if (kind == ext_bus_pkg::kind_write) begin
          next_low_out = wdata;
          next_low_oe  = 8'hff;
          next_wr_n    = 1'b0;
        end else if (kind == ext_bus_pkg::kind_read) begin
          next_low_oe = 8'h00;
          next_rd_n   = 1'b0;
        end else begin
          next_low_oe = 8'h00;
          next_pss    = 1'b0;
        end
      end
      ext_bus_pkg::st_strobe: begin
        next_count = count - 4'h1;
        next_low_out = (kind == ext_bus_pkg::kind_write) ? wdata : 8'h00;
        next_low_oe  = (kind == ext_bus_pkg::kind_write) ? 8'hff : 8'h00;
        next_wr_n    = ~((kind == ext_bus_pkg::kind_write) && (count > 4'h1));
        next_rd_n    = ~((kind == ext_bus_pkg::kind_read) && (count > 4'h1));
        next_pss     = ~((kind == ext_bus_pkg::kind_fetch) && (count > 4'h1));
        if (count == 4'h1) begin
          // Sample on last strobe cycle, before release
          if (kind != ext_bus_pkg::kind_write) begin
            next_rdata = low_port_in;
          end
          next_state = ext_bus_pkg::st_finish;
        end
      end
      ext_bus_pkg::st_finish: begin
        // Hold write data a second cycle after the rising strobe
        next_low_out   = (kind == ext_bus_pkg::kind_write) ? wdata : 8'h00;
        next_low_oe    = (kind == ext_bus_pkg::kind_write) ? 8'hff : od_enable(low_latch);
        next_done      = 1'b1;
        next_state     = ext_bus_pkg::st_idle;
        next_req_ready = 1'b1;
      end
      default: begin
        next_state = ext_bus_pkg::st_idle;
      end
    endcase
    if (state != ext_bus_pkg::st_idle || next_state != ext_bus_pkg::st_idle) begin
      if (next_state != ext_bus_pkg::st_idle) begin
        // High byte on fetch, middle byte on data; page rides page_out
        next_up_out = next_addr[15:8];
        next_up_oe  = 8'hff;
      end
    end
  end

  // Register stage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state                    <= ext_bus_pkg::st_idle;
      kind                     <= ext_bus_pkg::kind_fetch;
      addr                     <= '0;
      wdata                    <= 8'h00;
      count                    <= 4'h0;
      req_ready                <= 1'b0;
      fetch_internal           <= 1'b0;
      done                     <= 1'b0;
      rdata                    <= 8'h00;
      low_port_out             <= 8'h00;
      low_port_oe              <= 8'h00;
      upper_port_out           <= `PORT_LATCH_RESET;
      upper_port_oe            <= 8'hff;
      page_out                 <= 8'h00;
      ale                      <= 1'b0;
      rd_n                     <= 1'b1;
      wr_n                     <= 1'b1;
      program_store_strobe_out <= 1'b1;
      program_store_strobe_oe  <= 1'b0;
    end else begin
      state                    <= next_state;
      kind                     <= next_kind;
      addr                     <= next_addr;
      wdata                    <= next_wdata;
      count                    <= next_count;
      req_ready                <= next_req_ready;
      fetch_internal           <= next_fetch_internal;
      done                     <= next_done;
      rdata                    <= next_rdata;
      low_port_out             <= next_low_out;
      low_port_oe              <= next_low_oe;
      upper_port_out           <= next_up_out;
      upper_port_oe            <= next_up_oe;
      page_out                 <= next_page;
      ale                      <= next_ale;
      rd_n                     <= next_rd_n;
      wr_n                     <= next_wr_n;
      program_store_strobe_out <= next_pss;
      program_store_strobe_oe  <= next_pss_oe;
    end
  end

endmodule : external_memory_bus_port

// ### rtl/strap_capture.sv
`include "ext_bus_params.svh"
// Samples the download strap once just after reset release
module strap_capture (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic strap_pin,
  output logic      download_mode
);
  logic armed;       // Cleared after the single sample
  logic next_armed;
  logic next_download_mode;

  // Next values: one sample, then hold
  always_comb begin
    next_armed         = 1'b0;
    next_download_mode = download_mode;
    if (armed) begin
      next_download_mode = ~strap_pin;
    end
  end

  // Reset loads constants only; the pin is taken after release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      armed         <= 1'b1;
      download_mode <= 1'b0;
    end else begin
      armed         <= next_armed;
      download_mode <= next_download_mode;
    end
  end
endmodule : strap_capture

// ### shared/ext_bus_params.svh
`ifndef EXT_BUS_PARAMS_SVH
`define EXT_BUS_PARAMS_SVH
// Internal code window top, fetches above go outside
`define INTERNAL_CODE_TOP       16'h1fff
// Oscillator periods per program store strobe slot
`define FETCH_SLOT_PERIODS      4'h6
// Address latch strobe high phase, in clocks
`define ALE_HIGH_CYCLES         4'h1
// Data strobe width, in clocks
`define STROBE_CYCLES           4'h2
// Port latch reset value, all ones
`define PORT_LATCH_RESET        8'hff
`endif

// ### shared/ext_bus_pkg.sv
package ext_bus_pkg;
  // Bus cycle kind
  typedef enum logic [1:0] {
    kind_fetch = 2'b00,
    kind_read  = 2'b01,
    kind_write = 2'b10
  } kind_t;
  // Bus sequencer states
  typedef enum logic [2:0] {
    st_idle    = 3'b000,
    st_address = 3'b001,
    st_turn    = 3'b010,
    st_strobe  = 3'b011,
    st_finish  = 3'b100
  } state_t;
endpackage : ext_bus_pkg
